// ==== include/phy_regs_map.svh ====
// Offsets, bit positions, reset values and timing of the PHY control block.
// Assumes a 32-bit classic Wishbone bus and a 10 MHz system clock.
// Function
// [RQ1] Two-bit code picks transmit FIFO depth 4/5/6/8 nibbles; resets to 01.
// [RQ2] Force-link-good bit forces link enable for the basic control speed.
// [RQ3] Code 01 powers down all but management; PLL too if PLL-disable set.
// [RQ4] Code 10 is active sleep plus a wake link pulse every 1.4 s.
// [RQ5] Code 11 keeps management and energy detect; wakes on link partner.
// [RQ6] Controller must also set basic control power-down bit for these modes.
// [RQ7] With PLL powered down, logic runs from the reference clock.
// [RQ8] Auto crossover runs while its enable is one; reset value from strap.
// [RQ9] With auto crossover off, manual bit picks straight or crossed pinout.
// [RQ10] Jabber-disable bit one turns jabber detection off.
// [RQ11] Status shows speed (1 = 100 Mb/s) and duplex (1 = full).
// [RQ12] Status holds a latched-high page-received bit.
// [RQ13] Negotiation-complete reads one when done or disabled.
// [RQ14] Status shows link up as one, down as zero.
// [RQ15] Status shows resolved crossover and sleep state.
// [RQ16] Status shows detected 10 Mb/s polarity, one for positive.
// [RQ17] Status bit 0 shows a jabber condition.
// [RQ18] One enable bit per interrupt event, all reset to disabled.
// [RQ19] Each event latches into a flag; enabled flags drive the interrupt.
// [RQ20] Latched bits clear on read only if the condition has gone.
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH
`define IDX_PHY_CONTROL 6'h10
`define IDX_PHY_STATUS 6'h11
`define IDX_INT_MASK 6'h12
`define IDX_INT_FLAG 6'h13
`define CTRL_RESET 16'h4000
`define CTRL_WMASK 16'hc7f1
`define MASK_RESET 16'h0000
`define MASK_WMASK 16'hfcd3
`define CT_DEPTH 15:14
`define CT_FORCE 10
`define CT_PDMODE 9:8
`define CT_SLEEP 9
`define CT_AUTOX 6
`define CT_MANX 5
`define CT_PLLDIS 4
`define CT_JABDIS 0
`define ST_SPEED 14
`define ST_DUPLEX 13
`define ST_PAGE 12
`define ST_ANDONE 11
`define ST_LINK 10
`define ST_MDIX 8
`define ST_SLEEP 6
`define ST_POL 1
`define ST_JAB 0
`define FL_ANERR 15
`define FL_SPEED 14
`define FL_DUPLEX 13
`define FL_PAGE 12
`define FL_ANDONE 11
`define FL_LINK 10
`define FL_FIFO 7
`define FL_MDIX 6
`define FL_SLEEP 4
`define FL_POL 1
`define FL_JAB 0
`define DEPTH_C0 4'h4
`define DEPTH_C1 4'h5
`define DEPTH_C2 4'h6
`define DEPTH_C3 4'h8
`define NLP_PERIOD_MS 64'd1400
`define CLK_FREQ_HZ 64'd10000000
`define MS_PER_S 64'd1000
`endif

// ==== include/phy_regs_pkg.sv ====
// Types shared by the PHY control block.
// Assumes the constants of phy_regs_map.svh.
package phy_regs_pkg;
  typedef enum logic [1:0] {
    PD_NORMAL = 2'h0,
    PD_GENERAL = 2'h1,
    PD_ACTIVE_SLEEP = 2'h2,
    PD_PASSIVE_SLEEP = 2'h3
  } pd_mode_t;
  typedef enum logic [1:0] {PS_RUN, PS_PDOWN, PS_SLEEP, PS_AWAKE} pwr_state_t;
endpackage : phy_regs_pkg

// ==== design/phy_control_status_intmask.sv ====
// Control, status and interrupt-mask registers of a 10/100 PHY, Wishbone slave.
// Line-side status inputs come from logic on sys_clk; strap and energy pins do not.
`timescale 1ns/10ps
`include "phy_regs_map.svh"
module phy_control_status_intmask #(
  parameter logic [23:0] NLP_CYCLES =
    24'((`NLP_PERIOD_MS * `CLK_FREQ_HZ) / `MS_PER_S)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bmcrPowerDown,
  input wire logic bmcrSpeed100,
  input wire logic autoMdixStrap,
  input wire logic energyDetect,
  input wire logic lineSpeed100,
  input wire logic lineFullDuplex,
  input wire logic anEnabled,
  input wire logic anComplete,
  input wire logic anError,
  input wire logic pageReceived,
  input wire logic linkUp,
  input wire logic mdixResolved,
  input wire logic rxPolarity,
  input wire logic jabberDetect,
  input wire logic fifoFault,
  output logic [3:0] fifoDepth_q,
  output logic forcedLinkEnable10_q,
  output logic forcedLinkEnable100_q,
  output logic powerDownMain_q,
  output logic pllPowerDown_q,
  output logic clkSelRef_q,
  output logic nlpWake_q,
  output logic autoMdixEnable_q,
  output logic mdiCrossed_q,
  output logic jabberEnable_q,
  output logic irqPending_q
);
  logic [15:0] ctrl_q;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic pageLatch_q;
  logic pageLatch_d;
  logic [15:0] pageVec;
  logic [6:0] prev_q;
  logic [6:0] cur;
  logic [15:0] events;
  logic [15:0] status;
  logic [15:0] wrMask;
  logic [15:0] rdData;
  logic [5:0] idx;
  logic access;
  logic wrCtrl;
  logic wrMaskReg;
  logic rdStat;
  logic rdFlag;
  logic strapS1_q;
  logic strapS2_q;
  logic strapLoad_q;
  logic energyS1_q;
  logic energyS2_q;
  logic [23:0] nlpCount_q;
  logic anDone;
  phy_regs_pkg::pwr_state_t pwr_q;
  phy_regs_pkg::pwr_state_t pwr_d;
  phy_regs_pkg::pd_mode_t pdMode;

  // Set wins over the read clear, so an event in the read cycle survives
  function automatic logic [15:0] latchHigh(input logic [15:0] q, input logic [15:0] set,
                                            input logic rd);
    latchHigh = set | (q & ~{16{rd}});
  endfunction : latchHigh

  function automatic logic [3:0] depthOf(input logic [1:0] code);
    case (code)
      2'h0: depthOf = `DEPTH_C0;
      2'h1: depthOf = `DEPTH_C1;
      2'h2: depthOf = `DEPTH_C2;
      default: depthOf = `DEPTH_C3;
    endcase
  endfunction : depthOf

  // Strap and energy pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    strapS1_q <= autoMdixStrap;
    strapS2_q <= strapS1_q;
    energyS1_q <= energyDetect;
    energyS2_q <= energyS1_q;
  end

  assign idx = wb_adr_i[7:2];
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrCtrl = access & wb_we_i & (idx == `IDX_PHY_CONTROL);
  assign wrMaskReg = access & wb_we_i & (idx == `IDX_INT_MASK);
  assign rdStat = access & ~wb_we_i & (idx == `IDX_PHY_STATUS);
  assign rdFlag = access & ~wb_we_i & (idx == `IDX_INT_FLAG);
  assign pdMode = phy_regs_pkg::pd_mode_t'(ctrl_q[`CT_PDMODE]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // Seed one cycle after reset, so a short reset still sees a settled strap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strapLoad_q <= 1'b1;
    end else begin
      strapLoad_q <= 1'b0;
    end
  end

  // [RQ8] Strap seeds auto crossover
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= (ctrl_q & ~(wrMask & `CTRL_WMASK)) | (wb_dat_i[15:0] & wrMask & `CTRL_WMASK);
    end else if (strapLoad_q) begin
      ctrl_q[`CT_AUTOX] <= strapS2_q;
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (wrMaskReg) begin
      mask_d = (mask_q & ~(wrMask & `MASK_WMASK)) | (wb_dat_i[15:0] & wrMask & `MASK_WMASK);
    end
  end

  // [RQ18] Per-event enables
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= `MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // [RQ1] FIFO depth decode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fifoDepth_q <= `DEPTH_C1;
    end else begin
      fifoDepth_q <= depthOf(ctrl_q[`CT_DEPTH]);
    end
  end

  // [RQ2] Forced link for the chosen speed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      forcedLinkEnable10_q <= 1'b0;
      forcedLinkEnable100_q <= 1'b0;
    end else begin
      forcedLinkEnable10_q <= ctrl_q[`CT_FORCE] & ~bmcrSpeed100;
      forcedLinkEnable100_q <= ctrl_q[`CT_FORCE] & bmcrSpeed100;
    end
  end

  // [RQ9] Manual pinout when auto is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      autoMdixEnable_q <= 1'b0;
      mdiCrossed_q <= 1'b0;
      jabberEnable_q <= 1'b1;
    end else begin
      autoMdixEnable_q <= ctrl_q[`CT_AUTOX];
      mdiCrossed_q <= ctrl_q[`CT_AUTOX] ? mdixResolved : ctrl_q[`CT_MANX];
      // [RQ10] Jabber detection gate
      jabberEnable_q <= ~ctrl_q[`CT_JABDIS];
    end
  end

  // [RQ6] Modes only take effect with the basic control power-down bit
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      phy_regs_pkg::PS_RUN: begin
        if (bmcrPowerDown && pdMode == phy_regs_pkg::PD_GENERAL) begin
          pwr_d = phy_regs_pkg::PS_PDOWN;
        end else if (bmcrPowerDown && ctrl_q[`CT_SLEEP]) begin
          pwr_d = phy_regs_pkg::PS_SLEEP;
        end
      end
      phy_regs_pkg::PS_PDOWN: begin
        if (!bmcrPowerDown || pdMode != phy_regs_pkg::PD_GENERAL) begin
          pwr_d = phy_regs_pkg::PS_RUN;
        end
      end
      phy_regs_pkg::PS_SLEEP: begin
        if (!bmcrPowerDown || !ctrl_q[`CT_SLEEP]) begin
          pwr_d = phy_regs_pkg::PS_RUN;
        // [RQ5] Wake on link partner energy
        end else if (energyS2_q) begin
          pwr_d = phy_regs_pkg::PS_AWAKE;
        end
      end
      phy_regs_pkg::PS_AWAKE: begin
        // Stays awake until software leaves the sleep mode
        if (!bmcrPowerDown || !ctrl_q[`CT_SLEEP]) begin
          pwr_d = phy_regs_pkg::PS_RUN;
        end
      end
      default: pwr_d = phy_regs_pkg::PS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_q <= phy_regs_pkg::PS_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // [RQ3] Power-down outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      powerDownMain_q <= 1'b0;
      pllPowerDown_q <= 1'b0;
      clkSelRef_q <= 1'b0;
    end else begin
      powerDownMain_q <= (pwr_d == phy_regs_pkg::PS_PDOWN) || (pwr_d == phy_regs_pkg::PS_SLEEP);
      pllPowerDown_q <= (pwr_d == phy_regs_pkg::PS_PDOWN) && ctrl_q[`CT_PLLDIS];
      // [RQ7] Reference clock while PLL is off
      clkSelRef_q <= (pwr_d == phy_regs_pkg::PS_PDOWN) && ctrl_q[`CT_PLLDIS];
    end
  end

  // [RQ4] Wake pulse cadence in active sleep
  always_ff @(posedge sys_clk) begin
    if (rst || pwr_q != phy_regs_pkg::PS_SLEEP || pdMode != phy_regs_pkg::PD_ACTIVE_SLEEP) begin
      nlpCount_q <= 24'h000000;
      nlpWake_q <= 1'b0;
    end else if (nlpCount_q >= NLP_CYCLES - 24'h000001) begin
      nlpCount_q <= 24'h000000;
      nlpWake_q <= 1'b1;
    end else begin
      nlpCount_q <= nlpCount_q + 24'h000001;
      nlpWake_q <= 1'b0;
    end
  end

  // [RQ13] Done when finished or negotiation off
  assign anDone = anComplete | ~anEnabled;
  assign cur = {lineSpeed100, lineFullDuplex, anDone, linkUp, mdiCrossed_q,
                pwr_q == phy_regs_pkg::PS_SLEEP, rxPolarity};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_q <= 7'h00;
    end else begin
      prev_q <= cur;
    end
  end

  always_comb begin
    events = 16'h0000;
    events[`FL_ANERR] = anError;
    events[`FL_SPEED] = cur[6] ^ prev_q[6];
    events[`FL_DUPLEX] = cur[5] ^ prev_q[5];
    events[`FL_PAGE] = pageReceived;
    events[`FL_ANDONE] = cur[4] & ~prev_q[4];
    events[`FL_LINK] = cur[3] ^ prev_q[3];
    events[`FL_FIFO] = fifoFault;
    events[`FL_MDIX] = cur[2] ^ prev_q[2];
    events[`FL_SLEEP] = cur[1] ^ prev_q[1];
    events[`FL_POL] = cur[0] ^ prev_q[0];
    // Jabber is a level; the flag holds while it lasts
    events[`FL_JAB] = jabberDetect & jabberEnable_q;
  end

  // [RQ20] Read clears only what is no longer present
  assign flags_d = latchHigh(flags_q, events, rdFlag);
  assign pageVec = latchHigh({15'h0000, pageLatch_q}, {15'h0000, pageReceived}, rdStat);
  assign pageLatch_d = pageVec[0];

  // [RQ19] Latched event flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= 16'h0000;
      pageLatch_q <= 1'b0;
      irqPending_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // [RQ12] Page received latch
      pageLatch_q <= pageLatch_d;
      // Next mask too, so an enable write acts together with the flags
      irqPending_q <= |(flags_d & mask_d);
    end
  end

  always_comb begin
    status = 16'h0000;
    // [RQ11] Speed and duplex
    status[`ST_SPEED] = lineSpeed100;
    status[`ST_DUPLEX] = lineFullDuplex;
    status[`ST_PAGE] = pageLatch_q;
    status[`ST_ANDONE] = anDone;
    // [RQ14] Live link state
    status[`ST_LINK] = linkUp;
    // [RQ15] Crossover and sleep
    status[`ST_MDIX] = mdiCrossed_q;
    status[`ST_SLEEP] = pwr_q == phy_regs_pkg::PS_SLEEP;
    // [RQ16] Polarity
    status[`ST_POL] = rxPolarity;
    // [RQ17] Jabber condition
    status[`ST_JAB] = jabberDetect & jabberEnable_q;
  end

  always_comb begin
    case (idx)
      `IDX_PHY_CONTROL: rdData = ctrl_q;
      `IDX_PHY_STATUS: rdData = status;
      `IDX_INT_MASK: rdData = mask_q;
      `IDX_INT_FLAG: rdData = flags_q;
      default: rdData = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= {16'h0000, rdData};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_flagRead;
    rdFlag && !events[`FL_LINK];
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property (access |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_depth_code: assert property (wrCtrl && wrMask[15] && wb_dat_i[15:14] == 2'h3 // [RQ1]
    |=> ##1 fifoDepth_q == `DEPTH_C3)
    else $error("depth code 11 did not give eight nibbles");
  a_force_speed: assert property (##1 forcedLinkEnable100_q == // [RQ2]
    ($past(ctrl_q[`CT_FORCE]) && $past(bmcrSpeed100)))
    else $error("forced link not tied to chosen speed");
  a_pll_clock: assert property (clkSelRef_q == pllPowerDown_q // [RQ7]
    && (pllPowerDown_q -> powerDownMain_q))
    else $error("pll off without reference clock or power down");
  a_sleep_wake: assert property (pwr_q == phy_regs_pkg::PS_SLEEP && bmcrPowerDown // [RQ5]
    && ctrl_q[`CT_SLEEP] && energyS2_q |=> pwr_q == phy_regs_pkg::PS_AWAKE)
    else $error("sleep did not wake on energy");
  a_nlp_pulse: assert property (nlpWake_q |=> !nlpWake_q) // [RQ4]
    else $error("wake pulse longer than one cycle");
  a_page_hold: assert property (pageReceived ##1 !rdStat |=> pageLatch_q) // [RQ12]
    else $error("page latch lost before read");
  a_flag_clear: assert property (flags_q[`FL_LINK] ##0 s_flagRead // [RQ20]
    |=> !flags_q[`FL_LINK])
    else $error("flag not cleared by read");
  a_flag_setwins: assert property (rdFlag && events[`FL_LINK] |=> flags_q[`FL_LINK]) // [RQ19]
    else $error("event lost in read cycle");
  a_irq_gate: assert property (##1 irqPending_q == |(flags_q & mask_q)) // [RQ19]
    else $error("interrupt not gated by enables");
  a_jab_gate: assert property (ctrl_q[`CT_JABDIS] |=> !jabberEnable_q) // [RQ10]
    else $error("jabber not disabled");
endmodule : phy_control_status_intmask

// ==== dv/mgmt_master_model.sv ====
// Management controller stand-in: classic Wishbone single-cycle master.
// Assumes a slave that answers each taken request with one ack.
`timescale 1ns/10ps
module mgmt_master_model (
  input wire logic sys_clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datOut,
  input wire logic [31:0] datIn,
  input wire logic ack
);
  initial begin
    {cyc, stb, we, adr, sel, datOut} = '0;
  end

  // Request held until ack is seen; bounded so a dead slave cannot hang the run
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    int n;
    ok = 1'h0;
    q = 16'h0000;
    @(posedge sys_clk);
    {cyc, stb, we, adr, sel, datOut} <= {2'h3, w, a, 4'h3, 16'h0000, d};
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk);
      if (ack === 1'h1) begin
        ok = 1'h1;
        q = datIn[15:0];
      end
    end
    {cyc, stb, we} <= 3'h0;
  endtask : access
endmodule : mgmt_master_model

// ==== dv/phy_control_status_intmask_tb.sv ====
// Self-checking bench for the PHY control, status and interrupt-mask registers.
// Assumes the master model owns the register bus; line-side inputs come from here.
`timescale 1ns/10ps
module phy_control_status_intmask_tb;
  localparam logic [23:0] NLP = 24'h000014;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] w;
    logic [15:0] r;
    logic [10:0] o;
  } row_t;
  logic sys_clk = 1'h0;
  logic rst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datOut, datIn;
  logic bmcrPowerDown, bmcrSpeed100, autoMdixStrap, energyDetect, lineSpeed100;
  logic lineFullDuplex, anEnabled, anComplete, anError, pageReceived, linkUp;
  logic mdixResolved, rxPolarity, jabberDetect, fifoFault, forcedLinkEnable10_q;
  logic forcedLinkEnable100_q, powerDownMain_q, pllPowerDown_q, clkSelRef_q, nlpWake_q;
  logic autoMdixEnable_q, mdiCrossed_q, jabberEnable_q, irqPending_q;
  logic [3:0] fifoDepth_q;
  logic [10:0] outs;
  int miscompares = 0;
  int nCompared = 0;
  int g;
  // Write value, read-back, then depth/force/power/crossover/jabber outputs
  row_t rows [7] = '{
    '{8'h40, 16'h0000, 16'h0000, 11'h201},
    '{8'h40, 16'h4421, 16'h4421, 11'h2a2},
    '{8'h40, 16'h8060, 16'h8060, 11'h305},
    '{8'h40, 16'hffff, 16'hc7f1, 11'h424},
    '{8'h48, 16'hffff, 16'hfcd3, 11'h424},
    '{8'h80, 16'hffff, 16'h0000, 11'h424},
    '{8'h44, 16'hffff, 16'h0000, 11'h424}
  };

  assign outs = {fifoDepth_q, forcedLinkEnable10_q, forcedLinkEnable100_q, powerDownMain_q,
                 pllPowerDown_q, autoMdixEnable_q, mdiCrossed_q, jabberEnable_q};

  phy_control_status_intmask #(.NLP_CYCLES(NLP)) DUT (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datOut), .wb_dat_o(datIn), .wb_ack_o(ack),
    .bmcrPowerDown(bmcrPowerDown), .bmcrSpeed100(bmcrSpeed100), .autoMdixStrap(autoMdixStrap),
    .energyDetect(energyDetect), .lineSpeed100(lineSpeed100), .lineFullDuplex(lineFullDuplex),
    .anEnabled(anEnabled), .anComplete(anComplete), .anError(anError),
    .pageReceived(pageReceived), .linkUp(linkUp), .mdixResolved(mdixResolved),
    .rxPolarity(rxPolarity), .jabberDetect(jabberDetect), .fifoFault(fifoFault),
    .fifoDepth_q(fifoDepth_q), .forcedLinkEnable10_q(forcedLinkEnable10_q),
    .forcedLinkEnable100_q(forcedLinkEnable100_q), .powerDownMain_q(powerDownMain_q),
    .pllPowerDown_q(pllPowerDown_q), .clkSelRef_q(clkSelRef_q), .nlpWake_q(nlpWake_q),
    .autoMdixEnable_q(autoMdixEnable_q), .mdiCrossed_q(mdiCrossed_q),
    .jabberEnable_q(jabberEnable_q), .irqPending_q(irqPending_q));

  mgmt_master_model mgmt (.sys_clk(sys_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .datOut(datOut), .datIn(datIn), .ack(ack));

  always #50 sys_clk = ~sys_clk;

  task automatic complete_run;
    $display("comparisons %0d, miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A bus cycle that never acks ends the run as a failure
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic ok;
    mgmt.access(w, a, d, q, ok);
    if (ok !== 1'h1) begin
      miscompares++;
      complete_run();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'h1, a, d, q);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    xfer(1'h0, a, 16'h0000, q);
    chk(32'(q), 32'(e));
  endtask : rdChk

  // Cycles up to the next wake pulse, capped so a silent output cannot hang
  task automatic nlpGap(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (nlpWake_q !== 1'h1 && n < 100);
  endtask : nlpGap

  initial begin
    {rst, bmcrSpeed100, autoMdixStrap, anEnabled} = 4'hf;
    {bmcrPowerDown, energyDetect, lineSpeed100, lineFullDuplex, anComplete, anError} = 6'h00;
    {pageReceived, linkUp, mdixResolved, rxPolarity, jabberDetect, fifoFault} = 6'h00;
    // Two reset edges; the strap seed lands on the first free edge
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rdChk(8'h40, 16'h4040);
    chk(32'(outs), 32'h285);
    rdChk(8'h48, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdChk(rows[i].a, rows[i].r);
      chk(32'(outs), 32'(rows[i].o));
    end
    wr(8'h40, 16'h0000);
    chk(32'(irqPending_q), 32'h1);
    rdChk(8'h4c, 16'h0040);
    {lineSpeed100, lineFullDuplex, linkUp, rxPolarity, jabberDetect, anEnabled} <= 6'h3e;
    repeat (3) @(posedge sys_clk);
    chk(32'(irqPending_q), 32'h1);
    rdChk(8'h44, 16'h6c03);
    rdChk(8'h4c, 16'h6c03);
    rdChk(8'h4c, 16'h0001);
    jabberDetect <= 1'h0;
    rdChk(8'h4c, 16'h0001);
    rdChk(8'h4c, 16'h0000);
    chk(32'(irqPending_q), 32'h0);
    wr(8'h48, 16'h0000);
    pageReceived <= 1'h1;
    @(posedge sys_clk);
    pageReceived <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(32'(irqPending_q), 32'h0);
    rdChk(8'h44, 16'h7c02);
    rdChk(8'h44, 16'h6c02);
    wr(8'h48, 16'h1000);
    repeat (3) @(posedge sys_clk);
    chk(32'(irqPending_q), 32'h1);
    rdChk(8'h4c, 16'h1000);
    repeat (2) @(posedge sys_clk);
    chk(32'(irqPending_q), 32'h0);
    bmcrPowerDown <= 1'h1;
    wr(8'h40, 16'h0110);
    repeat (3) @(posedge sys_clk);
    chk(32'(outs), 32'h219);
    chk(32'(clkSelRef_q), 32'h1);
    wr(8'h40, 16'h0300);
    repeat (3) @(posedge sys_clk);
    rdChk(8'h44, 16'h6c42);
    chk(32'(outs), 32'h211);
    energyDetect <= 1'h1;
    for (g = 0; g < 10 && powerDownMain_q !== 1'h0; g++) begin
      @(posedge sys_clk);
    end
    chk(32'(powerDownMain_q), 32'h0);
    energyDetect <= 1'h0;
    rdChk(8'h44, 16'h6c02);
    // woken state holds until the code is cleared, then active sleep
    wr(8'h40, 16'h0000);
    wr(8'h40, 16'h0200);
    nlpGap(g);
    nlpGap(g);
    chk(32'(g), 32'(NLP));
    chk(32'(powerDownMain_q), 32'h1);
    complete_run();
  end
endmodule : phy_control_status_intmask_tb
